// file: fic_pkg.sv
/*
 * Shared constants for the four-level interrupt controller: special
 * function register addresses, field positions, reset values, read masks,
 * source numbering, vector addresses and the controller's state record.
 * Assumes an 8-bit special function register space driven by the core.
 */
package fic_pkg;

    localparam int NUM_SRC = 16;
    localparam int IDX_W   = 4;
    localparam int LVL_W   = 2;
    localparam int NUM_LVL = 4;
    localparam int NUM_EXT = 4;

    // Register addresses
    localparam logic [7:0] ADDR_TIMER_CTRL   = 8'h88;
    localparam logic [7:0] ADDR_INT_ENABLE   = 8'hA8;
    localparam logic [7:0] ADDR_EXT_CTRL     = 8'hC0;
    localparam logic [7:0] ADDR_EXT_EN_ONE   = 8'hAD;
    localparam logic [7:0] ADDR_EXT_EN_TWO   = 8'hA5;
    localparam logic [7:0] ADDR_PRIO0_LOW    = 8'hB8;
    localparam logic [7:0] ADDR_PRIO0_HIGH   = 8'hB7;
    localparam logic [7:0] ADDR_PRIO1_LOW    = 8'hAE;
    localparam logic [7:0] ADDR_PRIO1_HIGH   = 8'hAF;
    localparam logic [7:0] ADDR_PRIO2_LOW    = 8'hB5;
    localparam logic [7:0] ADDR_PRIO2_HIGH   = 8'hB6;
    localparam logic [7:0] ADDR_POLARITY     = 8'hA1;
    localparam logic [7:0] ADDR_SRC_SELECT   = 8'hA2;

    // Reset value shared by every register
    localparam logic [7:0] REG_RESET = 8'h00;

    // Implemented bits; the rest read as zero
    localparam logic [7:0] MASK_FULL     = 8'hFF;
    localparam logic [7:0] MASK_INT_EN   = 8'hBF;
    localparam logic [7:0] MASK_SEVEN    = 8'h7F;
    localparam logic [7:0] MASK_ONE      = 8'h01;
    localparam logic [7:0] MASK_POLARITY = 8'h03;
    localparam logic [7:0] MASK_SRC_SEL  = 8'h0F;

    // Field positions
    localparam int IE_GLOBAL   = 7;
    localparam int TC_TF1      = 7;
    localparam int TC_TR1      = 6;
    localparam int TC_TF0      = 5;
    localparam int TC_TR0      = 4;
    localparam int TC_IE1      = 3;
    localparam int TC_IT1      = 2;
    localparam int TC_IE0      = 1;
    localparam int TC_IT0      = 0;
    localparam int XC_POL3     = 7;
    localparam int XC_EN3      = 6;
    localparam int XC_IE3      = 5;
    localparam int XC_IT3      = 4;
    localparam int XC_POL2     = 3;
    localparam int XC_EN2      = 2;
    localparam int XC_IE2      = 1;
    localparam int XC_IT2      = 0;
    localparam int SEL_W       = 2;

    // Source numbering, which is also the polling order (0 polls first)
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TMR1 = 3;
    localparam int SRC_EXT2 = 6;
    localparam int SRC_EXT3 = 7;

    // Sources whose flag lives in a peripheral and is cleared by software
    localparam logic [15:0] PERIPH_MASK = 16'hFF30;

    localparam logic [15:0] VEC_ADDR [NUM_SRC] = '{
        16'h0003, 16'h000B, 16'h0013, 16'h001B,
        16'h0023, 16'h002B, 16'h0033, 16'h003B,
        16'h0043, 16'h004B, 16'h0053, 16'h005B,
        16'h0063, 16'h006B, 16'h0073, 16'h0083
    };

    typedef struct packed {
        logic [7:0]  interrupt_enable;
        logic [7:0]  timer_counter_control;
        logic [7:0]  ext_irq_control;
        logic [7:0]  extended_enable_one;
        logic [7:0]  extended_enable_two;
        logic [7:0]  priority_zero_low;
        logic [7:0]  priority_zero_high;
        logic [7:0]  ext_priority_one_low;
        logic [7:0]  ext_priority_one_high;
        logic [7:0]  ext_priority_two_low;
        logic [7:0]  ext_priority_two_high;
        logic [7:0]  polarity_select;
        logic [7:0]  ext_source_select;
        logic [3:0]  active_prev;
        logic [15:0] sampled;
        logic [3:0]  in_service;
        logic        hold;
        logic        vector_call;
        logic [15:0] vector_addr;
        logic [1:0]  vector_level;
        logic [7:0]  rdata;
    } fic_state_t;

endpackage : fic_pkg

// file: fic_arbiter.sv
/*
 * Priority arbiter: picks the highest-level eligible request, lowest source
 * number first within a level. Purely combinational; the caller registers
 * everything it drives out.
 */
`timescale 1ns/100ps

module fic_arbiter #(
    parameter int NUM_SRC = 16,
    parameter int IDX_W   = 4
) (
    // Requests and their level bits
    input  wire logic [NUM_SRC-1:0] request,
    input  wire logic [NUM_SRC-1:0] prio_high,
    input  wire logic [NUM_SRC-1:0] prio_low,
    // One bit per level code of routines in progress
    input  wire logic [3:0]         in_service,
    // Winner
    output logic                    grant_valid,
    output logic [IDX_W-1:0]        grant_index,
    output logic [1:0]              grant_level
);

    logic [1:0]         level [NUM_SRC];
    logic [NUM_SRC-1:0] eligible;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : gen_src
            assign level[g] = {prio_high[g], prio_low[g]}; // see R3
            // Only a level above every routine in progress may enter
            assign eligible[g] = request[g] &&
                ((in_service >> level[g]) == 4'h0); // see R4, R10
        end
    endgenerate

    always_comb begin
        grant_valid = 1'b0;
        grant_index = '0;
        grant_level = 2'b00;
        // Scan down so that ties keep the lowest source number
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i] && (!grant_valid || level[i] >= grant_level)) begin
                grant_valid = 1'b1; // see R5, R6
                grant_index = IDX_W'(i); // see R7
                grant_level = level[i];
            end
        end
    end

endmodule : fic_arbiter

// file: fic_controller.sv
/*
 * Four-level interrupt controller for a multi-cycle core: enable and
 * priority registers, external-input detection, timer flags, flag sampling
 * and the vectored call handed to the core.
 * Assumes the core drives register accesses on the special function
 * register port, flags the last cycle of each instruction and the return
 * from an interrupt routine, and takes vector_call as a one-cycle request.
 */
`timescale 1ns/100ps

// Functional notes
// R1: sixteen sources, each with own enable bit
// R2: enable bit 7 gates every interrupt globally
// R3: high/low bit pair encodes four levels
// R4: lower level never preempts running routine
// R5: higher level wins among simultaneous requests
// R6: equal levels resolved by fixed polling order
// R7: source 1 polls first, each own vector; code polls source 0 first
// R8: flags sampled each cycle, polled next cycle
// R9: set sample issues call unless blocked
// R10: no call while equal/higher level runs
// R11: call only in instruction's final cycle
// R12: one instruction after return or register write; code holds on return or on writes to A8/B7/B8/AD/AE/AF only
// R13: inputs 2,3 polarity: low/fall or high/rise
// R14: power-down forces edge inputs level sensitive
// R15: inputs 2,3 source selectable among pins
// R16: inputs 0,1 flags set, edge cleared on call
// R17: type bit: level or edge; polarity inverts
// R18: timer control flag and type bit positions
// R19: software writes zero to enable bit 6
// R20: enable bit 5 gates timer 2
// R21: timer 0,1 flags cleared on vectoring
// R22: grouped peripheral flags left for software
// R23: software may set or clear every flag; code ignores writes to external flags in level mode
module fic_controller #(
    parameter int NUM_SRC = fic_pkg::NUM_SRC
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               reset,
    // Special function register port
    input  wire logic [7:0]         sfr_addr,
    input  wire logic               sfr_wr,
    input  wire logic [7:0]         sfr_wdata,
    output logic [7:0]              sfr_rdata,
    // Core status
    input  wire logic               instr_last_cycle,
    input  wire logic               reti_exec,
    input  wire logic               power_down,
    // External inputs; 2 and 3 offer four candidate pins each
    input  wire logic               ext_input_0,
    input  wire logic               ext_input_1,
    input  wire logic [3:0]         ext_input_2,
    input  wire logic [3:0]         ext_input_3,
    // Timer overflow pulses
    input  wire logic               tmr0_overflow,
    input  wire logic               tmr1_overflow,
    // Peripheral request levels, indexed by source number
    input  wire logic [NUM_SRC-1:0] periph_request,
    // Vectored call to the core
    output logic                    vector_call,
    output logic [15:0]             vector_addr,
    output logic [1:0]              vector_level,
    output logic [3:0]              in_service,
    // Timer run bits kept in the timer control register
    output logic                    tmr0_run,
    output logic                    tmr1_run
);

    fic_pkg::fic_state_t st;
    fic_pkg::fic_state_t next_st;

    logic [NUM_SRC-1:0]       flags;
    logic [NUM_SRC-1:0]       enables;
    logic [NUM_SRC-1:0]       prio_high;
    logic [NUM_SRC-1:0]       prio_low;
    logic [NUM_SRC-1:0]       vec_clear;
    logic                     grant_valid;
    logic [fic_pkg::IDX_W-1:0] grant_index;
    logic [1:0]               grant_level;
    logic                     cfg_write;
    logic                     block_now;
    logic                     issue;
    logic [3:0]               ext_pin;
    logic [3:0]               ext_pol;
    logic [3:0]               ext_type;
    logic [3:0]               ext_flag;
    logic [3:0]               ext_active;
    logic [3:0]               ext_edge_mode;
    logic [3:0]               ext_next;
    logic [3:0]               ext_written;
    logic [3:0]               ext_wbit;
    logic                     wr_tc;
    logic                     wr_xc;
    logic                     reti_done;
    logic [1:0]               sel2;
    logic [1:0]               sel3;

    // Routing of the shared-pin inputs
    assign sel2 = st.ext_source_select[fic_pkg::SEL_W-1:0];
    assign sel3 = st.ext_source_select[2*fic_pkg::SEL_W-1:fic_pkg::SEL_W];
    assign ext_pin = {ext_input_3[sel3], ext_input_2[sel2],
                      ext_input_1, ext_input_0}; // see R15

    assign ext_pol = {st.ext_irq_control[fic_pkg::XC_POL3],
                      st.ext_irq_control[fic_pkg::XC_POL2],
                      st.polarity_select[1:0]}; // see R13
    assign ext_type = {st.ext_irq_control[fic_pkg::XC_IT3],
                       st.ext_irq_control[fic_pkg::XC_IT2],
                       st.timer_counter_control[fic_pkg::TC_IT1],
                       st.timer_counter_control[fic_pkg::TC_IT0]}; // see R18
    assign ext_flag = {st.ext_irq_control[fic_pkg::XC_IE3],
                       st.ext_irq_control[fic_pkg::XC_IE2],
                       st.timer_counter_control[fic_pkg::TC_IE1],
                       st.timer_counter_control[fic_pkg::TC_IE0]}; // see R18

    // Polarity 0 watches low level or falling edge, 1 the inverse
    assign ext_active = ext_pin ^ ~ext_pol; // see R13, R17
    // Power-down has no clock to catch edges reliably, so force level mode
    assign ext_edge_mode = ext_type & {4{~power_down}}; // see R14

    assign wr_tc = sfr_wr && (sfr_addr == fic_pkg::ADDR_TIMER_CTRL);
    assign wr_xc = sfr_wr && (sfr_addr == fic_pkg::ADDR_EXT_CTRL);
    assign ext_written = {wr_xc, wr_xc, wr_tc, wr_tc};
    assign ext_wbit = {sfr_wdata[fic_pkg::XC_IE3],
                       sfr_wdata[fic_pkg::XC_IE2],
                       sfr_wdata[fic_pkg::TC_IE1],
                       sfr_wdata[fic_pkg::TC_IE0]};

    // Request flags in source order
    always_comb begin
        flags = periph_request & fic_pkg::PERIPH_MASK; // see R22
        flags[fic_pkg::SRC_EXT0] = ext_flag[0];
        flags[fic_pkg::SRC_TMR0] =
            st.timer_counter_control[fic_pkg::TC_TF0];
        flags[fic_pkg::SRC_EXT1] = ext_flag[1];
        flags[fic_pkg::SRC_TMR1] =
            st.timer_counter_control[fic_pkg::TC_TF1];
        flags[fic_pkg::SRC_EXT2] = ext_flag[2];
        flags[fic_pkg::SRC_EXT3] = ext_flag[3];
    end

    // Enable bits in source order; bit 5 of the main register is timer 2
    assign enables = {st.extended_enable_two[0],
                      st.extended_enable_one[6:0],
                      st.ext_irq_control[fic_pkg::XC_EN3],
                      st.ext_irq_control[fic_pkg::XC_EN2],
                      st.interrupt_enable[5:0]}; // see R1, R20
    assign prio_high = {st.ext_priority_two_high[0],
                        st.ext_priority_one_high[6:0],
                        st.priority_zero_high}; // see R3
    assign prio_low = {st.ext_priority_two_low[0],
                       st.ext_priority_one_low[6:0],
                       st.priority_zero_low}; // see R3

    fic_arbiter #(
        .NUM_SRC     (NUM_SRC),
        .IDX_W       (fic_pkg::IDX_W)
    ) u_arbiter (
        .request     (st.sampled),
        .prio_high   (prio_high),
        .prio_low    (prio_low),
        .in_service  (st.in_service),
        .grant_valid (grant_valid),
        .grant_index (grant_index),
        .grant_level (grant_level)
    );

    // Writes that must let one more instruction run before a call
    assign cfg_write = sfr_wr && (sfr_addr == fic_pkg::ADDR_INT_ENABLE ||
                                  sfr_addr == fic_pkg::ADDR_PRIO0_LOW ||
                                  sfr_addr == fic_pkg::ADDR_PRIO0_HIGH ||
                                  sfr_addr == fic_pkg::ADDR_EXT_EN_ONE ||
                                  sfr_addr == fic_pkg::ADDR_PRIO1_LOW ||
                                  sfr_addr == fic_pkg::ADDR_PRIO1_HIGH);
    assign block_now = st.hold || cfg_write || reti_exec; // see R12
    assign issue = grant_valid && instr_last_cycle && !block_now; // see R9, R11

    // Hardware clear on vectoring: timers always, external inputs in edge mode
    always_comb begin
        vec_clear = '0;
        if (issue) begin
            vec_clear[grant_index] = 1'b1;
        end
        vec_clear[fic_pkg::SRC_EXT0] = vec_clear[fic_pkg::SRC_EXT0] &
                                       ext_type[0]; // see R16
        vec_clear[fic_pkg::SRC_EXT1] = vec_clear[fic_pkg::SRC_EXT1] &
                                       ext_type[1]; // see R16
        vec_clear[fic_pkg::SRC_EXT2] = vec_clear[fic_pkg::SRC_EXT2] &
                                       ext_type[2];
        vec_clear[fic_pkg::SRC_EXT3] = vec_clear[fic_pkg::SRC_EXT3] &
                                       ext_type[3];
    end

    // External flags: edge latches until vectored or cleared, level follows
    always_comb begin
        ext_next = '0;
        for (int i = 0; i < fic_pkg::NUM_EXT; i++) begin
            if (ext_edge_mode[i]) begin
                ext_next[i] = (ext_written[i] ? ext_wbit[i]
                               : ext_flag[i]) |
                              (ext_active[i] & ~st.active_prev[i]); // see R23
            end else begin
                ext_next[i] = ext_active[i]; // see R16, R17
            end
        end
        ext_next[0] = ext_next[0] & ~(vec_clear[fic_pkg::SRC_EXT0] &
            (st.active_prev[0] | ~ext_active[0]));
        ext_next[1] = ext_next[1] & ~(vec_clear[fic_pkg::SRC_EXT1] &
            (st.active_prev[1] | ~ext_active[1]));
        ext_next[2] = ext_next[2] & ~(vec_clear[fic_pkg::SRC_EXT2] &
            (st.active_prev[2] | ~ext_active[2]));
        ext_next[3] = ext_next[3] & ~(vec_clear[fic_pkg::SRC_EXT3] &
            (st.active_prev[3] | ~ext_active[3]));
    end

    always_comb begin
        next_st = st;
        next_st.vector_call = 1'b0;
        reti_done = 1'b0;

        if (sfr_wr) begin
            case (sfr_addr)
                fic_pkg::ADDR_INT_ENABLE:
                    // Bit 6 is held at zero whatever software writes
                    next_st.interrupt_enable =
                        sfr_wdata & fic_pkg::MASK_INT_EN; // see R19
                fic_pkg::ADDR_TIMER_CTRL:
                    next_st.timer_counter_control = sfr_wdata; // see R23
                fic_pkg::ADDR_EXT_CTRL:
                    next_st.ext_irq_control = sfr_wdata;
                fic_pkg::ADDR_EXT_EN_ONE:
                    next_st.extended_enable_one =
                        sfr_wdata & fic_pkg::MASK_SEVEN;
                fic_pkg::ADDR_EXT_EN_TWO:
                    next_st.extended_enable_two =
                        sfr_wdata & fic_pkg::MASK_ONE;
                fic_pkg::ADDR_PRIO0_LOW:
                    next_st.priority_zero_low = sfr_wdata;
                fic_pkg::ADDR_PRIO0_HIGH:
                    next_st.priority_zero_high = sfr_wdata;
                fic_pkg::ADDR_PRIO1_LOW:
                    next_st.ext_priority_one_low =
                        sfr_wdata & fic_pkg::MASK_SEVEN;
                fic_pkg::ADDR_PRIO1_HIGH:
                    next_st.ext_priority_one_high =
                        sfr_wdata & fic_pkg::MASK_SEVEN;
                fic_pkg::ADDR_PRIO2_LOW:
                    next_st.ext_priority_two_low =
                        sfr_wdata & fic_pkg::MASK_ONE;
                fic_pkg::ADDR_PRIO2_HIGH:
                    next_st.ext_priority_two_high =
                        sfr_wdata & fic_pkg::MASK_ONE;
                fic_pkg::ADDR_POLARITY:
                    next_st.polarity_select =
                        sfr_wdata & fic_pkg::MASK_POLARITY;
                fic_pkg::ADDR_SRC_SELECT:
                    next_st.ext_source_select =
                        sfr_wdata & fic_pkg::MASK_SRC_SEL;
                default: ;
            endcase
        end

        // Hardware sets win over a software or vectoring clear
        next_st.timer_counter_control[fic_pkg::TC_TF0] =
            (next_st.timer_counter_control[fic_pkg::TC_TF0] &
             ~(vec_clear[fic_pkg::SRC_TMR0] & ~wr_tc)) |
            tmr0_overflow; // see R21, R23
        next_st.timer_counter_control[fic_pkg::TC_TF1] =
            (next_st.timer_counter_control[fic_pkg::TC_TF1] &
             ~(vec_clear[fic_pkg::SRC_TMR1] & ~wr_tc)) |
            tmr1_overflow; // see R21, R23
        next_st.timer_counter_control[fic_pkg::TC_IE0] = ext_next[0];
        next_st.timer_counter_control[fic_pkg::TC_IE1] = ext_next[1];
        next_st.ext_irq_control[fic_pkg::XC_IE2] = ext_next[2];
        next_st.ext_irq_control[fic_pkg::XC_IE3] = ext_next[3];
        next_st.active_prev = ext_active;

        // Sample this cycle, poll next cycle
        next_st.sampled = flags & enables &
            {NUM_SRC{st.interrupt_enable[fic_pkg::IE_GLOBAL]}}; // see R2, R8

        // Hold covers the rest of this instruction and, when raised in its
        // last cycle, the instruction itself only
        next_st.hold = (st.hold || cfg_write || reti_exec) &&
                       !instr_last_cycle; // see R12

        // Return retires the highest level in progress
        if (reti_exec) begin
            for (int l = fic_pkg::NUM_LVL - 1; l >= 0; l--) begin
                if (!reti_done && st.in_service[l]) begin
                    next_st.in_service[l] = 1'b0;
                    reti_done = 1'b1;
                end
            end
        end

        if (issue) begin
            next_st.vector_call = 1'b1; // see R9
            next_st.vector_addr = fic_pkg::VEC_ADDR[grant_index]; // see R7
            next_st.vector_level = grant_level;
            next_st.in_service[grant_level] = 1'b1; // see R10
        end

        case (sfr_addr)
            fic_pkg::ADDR_INT_ENABLE: next_st.rdata = st.interrupt_enable;
            fic_pkg::ADDR_TIMER_CTRL: next_st.rdata = st.timer_counter_control;
            fic_pkg::ADDR_EXT_CTRL:   next_st.rdata = st.ext_irq_control;
            fic_pkg::ADDR_EXT_EN_ONE: next_st.rdata = st.extended_enable_one;
            fic_pkg::ADDR_EXT_EN_TWO: next_st.rdata = st.extended_enable_two;
            fic_pkg::ADDR_PRIO0_LOW:  next_st.rdata = st.priority_zero_low;
            fic_pkg::ADDR_PRIO0_HIGH: next_st.rdata = st.priority_zero_high;
            fic_pkg::ADDR_PRIO1_LOW:  next_st.rdata = st.ext_priority_one_low;
            fic_pkg::ADDR_PRIO1_HIGH: next_st.rdata = st.ext_priority_one_high;
            fic_pkg::ADDR_PRIO2_LOW:  next_st.rdata = st.ext_priority_two_low;
            fic_pkg::ADDR_PRIO2_HIGH: next_st.rdata = st.ext_priority_two_high;
            fic_pkg::ADDR_POLARITY:   next_st.rdata = st.polarity_select;
            fic_pkg::ADDR_SRC_SELECT: next_st.rdata = st.ext_source_select;
            default:                  next_st.rdata = fic_pkg::REG_RESET;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st.interrupt_enable      <= fic_pkg::REG_RESET;
            st.timer_counter_control <= fic_pkg::REG_RESET;
            st.ext_irq_control       <= fic_pkg::REG_RESET;
            st.extended_enable_one   <= fic_pkg::REG_RESET;
            st.extended_enable_two   <= fic_pkg::REG_RESET;
            st.priority_zero_low     <= fic_pkg::REG_RESET;
            st.priority_zero_high    <= fic_pkg::REG_RESET;
            st.ext_priority_one_low  <= fic_pkg::REG_RESET;
            st.ext_priority_one_high <= fic_pkg::REG_RESET;
            st.ext_priority_two_low  <= fic_pkg::REG_RESET;
            st.ext_priority_two_high <= fic_pkg::REG_RESET;
            st.polarity_select       <= fic_pkg::REG_RESET;
            st.ext_source_select     <= fic_pkg::REG_RESET;
            // Treat inputs as active at reset so no false edge is seen
            st.active_prev           <= '1;
            st.sampled               <= '0;
            st.in_service            <= '0;
            st.hold                  <= 1'b0;
            st.vector_call           <= 1'b0;
            st.vector_addr           <= '0;
            st.vector_level          <= '0;
            st.rdata                 <= fic_pkg::REG_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign sfr_rdata    = st.rdata;
    assign vector_call  = st.vector_call;
    assign vector_addr  = st.vector_addr;
    assign vector_level = st.vector_level;
    assign in_service   = st.in_service;
    assign tmr0_run     = st.timer_counter_control[fic_pkg::TC_TR0];
    assign tmr1_run     = st.timer_counter_control[fic_pkg::TC_TR1];

endmodule : fic_controller

// file: fic_sva.sv
/* Vector call checks on the controller ports.
   Bound to fic_controller from the testbench top file. */
`timescale 1ns/100ps
module fic_sva (
    // Watched ports
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        instr_last_cycle,
    input wire logic        reti_exec,
    input wire logic        sfr_wr,
    input wire logic [7:0]  sfr_addr,
    input wire logic        vector_call,
    input wire logic [15:0] vector_addr,
    input wire logic [1:0]  vector_level,
    input wire logic [3:0]  in_service
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_pulse; vector_call |=> !vector_call; endproperty
    a_pulse: assert property (p_pulse) else $error("long call");
    property p_last; vector_call |-> $past(instr_last_cycle); endproperty
    a_last: assert property (p_last) else $error("call mid op");
    property p_reti; vector_call |-> !$past(reti_exec); endproperty
    a_reti: assert property (p_reti) else $error("call on return");
    property p_cfg; vector_call |-> !$past(sfr_wr && sfr_addr == 8'hA8);
    endproperty
    a_cfg: assert property (p_cfg) else $error("call on write");
    property p_above;
        vector_call |-> ($past(in_service) >> vector_level) == 4'h0;
    endproperty
    a_above: assert property (p_above) else $error("preempted");
    property p_mark; vector_call |-> in_service[vector_level]; endproperty
    a_mark: assert property (p_mark) else $error("not marked");
    property p_rise; !vector_call |-> (in_service & ~$past(in_service)) == 4'h0;
    endproperty
    a_rise: assert property (p_rise) else $error("stray level");
    property p_vec;
        vector_call |-> vector_addr[2:0] == 3'h3 && vector_addr <= 16'h0083;
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    c_call: cover property (vector_call);
    c_top: cover property (vector_call && vector_level == 2'h3);
    c_ret: cover property (reti_exec && in_service != 4'h0);
endmodule : fic_sva

// file: fic_core_model.sv
/* Core stand-in: flags instruction ends and returns from each routine.
   Assumes vector_call is a one-cycle pulse. */
`timescale 1ns/100ps
module fic_core_model (
    // Clock and pacing
    input  wire logic clk_sys,
    input  wire logic slow,
    // Call side
    input  wire logic vector_call,
    output logic      instr_last_cycle = 1'b0,
    output logic      reti_exec = 1'b0
);
    logic [2:0] cnt  = 3'h0;
    logic [5:0] seen = 6'h00;
    // Slow pace ends an instruction every eighth cycle only
    always @(negedge clk_sys) begin
        cnt <= cnt + 3'h1;
        seen <= {seen[4:0], vector_call};
        instr_last_cycle <= !slow || cnt == 3'h0;
        reti_exec <= seen[5];
    end
endmodule : fic_core_model

// file: fic_tb.sv
/* Bench: register port, priority order, global gate and pin edge.
   Assumes controller, core model and checker are compiled first. */
`timescale 1ns/100ps
module testbench;
    logic clk_sys = 1'b0, reset = 1'b1, sfr_wr = 1'b0, slow = 1'b0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, r;
    logic ext_input_0 = 1'b1, instr_last_cycle, reti_exec, vector_call;
    logic [15:0] vector_addr, expq [$], periph_request = 16'h0000;
    logic tmr0_overflow = 1'b0;
    logic [1:0]  vector_level;
    logic [3:0]  in_service;
    int n_errors = 0, comparisons = 0;
    always #20 clk_sys = ~clk_sys;
    fic_controller dut_u (.clk_sys, .reset, .sfr_addr, .sfr_wr, .sfr_wdata,
        .sfr_rdata, .instr_last_cycle, .reti_exec, .power_down(1'b0),
        .ext_input_0, .ext_input_1(1'b1), .ext_input_2(4'hF),
        .ext_input_3(4'hF), .tmr0_overflow, .tmr1_overflow(1'b0),
        .periph_request, .vector_call, .vector_addr,
        .vector_level, .in_service, .tmr0_run(), .tmr1_run());
    fic_core_model core_u (.clk_sys, .slow, .vector_call, .instr_last_cycle,
        .reti_exec);
    task automatic check(input logic [15:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, exp);
        @(negedge clk_sys);
        sfr_addr = a;
        @(negedge clk_sys);
        check({8'h00, sfr_rdata}, {8'h00, exp});
    endtask : rd
    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic drain(input string name);
        repeat (300) if (expq.size() != 0) @(negedge clk_sys);
        if (expq.size() != 0) begin
            n_errors++;
            close_out();
        end
        $display("test %s done", name);
    endtask : drain
    // A call with nothing expected is compared against an impossible vector
    always @(negedge clk_sys) if (vector_call === 1'b1) begin
        if (expq.size() == 0) check(vector_addr, 16'hFFFF);
        else check(vector_addr, expq.pop_front());
    end
    initial begin
        void'($urandom(50631));
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        periph_request = 16'($urandom());
        rd(8'hA8, 8'h00);
        rd(8'h88, 8'h00);
        r = 8'($urandom()) & 8'h3F;
        wr(8'hA8, r);
        rd(8'hA8, r);
        rd(8'h3C, 8'h00);
        wr(8'h88, 8'h05);
        wr(8'h88, 8'h2F);
        wr(8'hB7, 8'h04);
        wr(8'hB8, 8'h04);
        expq = '{16'h0013, 16'h0003, 16'h000B};
        wr(8'hA8, 8'h87);
        drain("priority");
        rd(8'h88, 8'h05);
        slow = 1'b1;
        wr(8'hA8, 8'h01);
        wr(8'h88, 8'h03);
        repeat (30) @(negedge clk_sys);
        expq.push_back(16'h0003);
        wr(8'hA8, 8'h83);
        drain("global");
        slow = 1'b0;
        repeat ($urandom_range(9)) @(negedge clk_sys);
        expq = '{16'h0003, 16'h000B};
        ext_input_0 = 1'b0;
        tmr0_overflow = 1'b1;
        @(negedge clk_sys) tmr0_overflow = 1'b0;
        drain("edge");
        ext_input_0 = 1'b1;
        close_out();
    end
endmodule : testbench
bind fic_controller fic_sva chk_u (.clk_sys, .reset, .instr_last_cycle,
    .reti_exec, .sfr_wr, .sfr_addr, .vector_call, .vector_addr,
    .vector_level, .in_service);
